// [adc_limit_alert_monitor.sv]
`include "alert_mon_cfg.svh"
`timescale 1ns/100ps
module adc_limit_alert_monitor
  import limits_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic conv_clk,
  input wire logic conv_done,
  input wire logic [1:0] conv_channel,
  input wire logic [11:0] conv_result,
  input wire logic [3:0] addr_strap,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic shared_flag_output_pin
);
  localparam mon_state_t MON_RESET = '{
    state: ST_IDLE,
    flags: `RST_FLAGS,
    lower: {4{`RST_LOWER}},
    upper: {4{`RST_UPPER}},
    margin: {4{`RST_MARGIN}},
    default: '0
  };

  logic rst_q;
  logic rst_c;
  logic [1:0] pins_s;
  logic [3:0] strap_s;
  logic tgl_s;
  logic scl_f;
  logic sda_f;

  conv_state_t cv;
  conv_state_t next_cv;
  mon_state_t st;
  mon_state_t next_st;

  logic cv_evt;
  logic [1:0] cv_ch;
  logic [11:0] cv_val;
  logic [11:0] c_up;
  logic [11:0] c_lo;
  logic [11:0] c_m;
  logic [7:0] set;
  logic clr;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic hit;
  logic [1:0] sch;
  logic [1:0] skind;
  logic [11:0] sel_val;
  logic [7:0] tx_byte;
  logic tx_load;
  logic wr_en;
  logic [11:0] wr_val;

  // ----------------------------------------
  // resets and input synchronisers
  // ----------------------------------------
  sync2 #(.W(1), .INIT(1'b0)) u_rst_sync (
    .clk(clk), .rst_n(rst_n), .d(1'b1), .q(rst_q)
  );
  sync2 #(.W(1), .INIT(1'b0)) u_rst_conv (
    .clk(conv_clk), .rst_n(rst_n), .d(1'b1), .q(rst_c)
  );
  // bus idles high, so the pin copies start high
  sync2 #(.W(2), .INIT(2'h3)) u_pin_sync (
    .clk(clk), .rst_n(rst_q), .d({scl_in, sda_in}), .q(pins_s)
  );
  sync2 #(.W(4), .INIT(4'h0)) u_strap_sync (
    .clk(clk), .rst_n(rst_q), .d(addr_strap), .q(strap_s)
  );
  sync2 #(.W(1), .INIT(1'b0)) u_tgl_sync (
    .clk(clk), .rst_n(rst_q), .d(cv.tgl), .q(tgl_s)
  );

  spike_filter #(.CYC(8'(`SPIKE_CYC))) u_scl_filt (
    .clk(clk), .rst_n(rst_q), .d(pins_s[1]), .q(scl_f)
  );
  spike_filter #(.CYC(8'(`SPIKE_CYC))) u_sda_filt (
    .clk(clk), .rst_n(rst_q), .d(pins_s[0]), .q(sda_f)
  );

  // ----------------------------------------
  // conversion capture, converter clock
  // ----------------------------------------
  // result and channel are held until the next conversion; the toggle
  // crossing needs a few clk cycles, far below any conversion period
  always_comb begin
    next_cv = cv;
    if (conv_done) begin
      next_cv.ch = conv_channel;
      next_cv.val = conv_result;
      next_cv.tgl = ~cv.tgl;
    end
  end

  always_ff @(posedge conv_clk or negedge rst_c) begin
    if (!rst_c) begin
      cv <= '0;
    end else begin
      cv <= next_cv;
    end
  end

  assign cv_evt = tgl_s ^ st.tgl_q;
  assign cv_ch = cv.ch;
  assign cv_val = cv.val;
  assign c_up = st.upper[cv_ch];
  assign c_lo = st.lower[cv_ch];
  assign c_m = st.margin[cv_ch];

  // ----------------------------------------
  // pointer decode and read mux
  // ----------------------------------------
  always_comb begin
    hit = 1'b0;
    sch = 2'h0;
    skind = 2'h0;
    for (int i = 0; i < 4; i++) begin
      for (int k = 0; k < 3; k++) begin
        if (st.ptr == 8'(`OFF_LOWER0 + `OFF_STRIDE * i + k)) begin
          hit = 1'b1;
          sch = 2'(i);
          skind = 2'(k);
        end
      end
    end
    unique case (skind)
      2'h0: sel_val = st.lower[sch];
      2'h1: sel_val = st.upper[sch];
      default: sel_val = st.margin[sch];
    endcase
    if (st.ptr == `OFF_ALERT) begin
      tx_byte = st.flags;
    end else if (!hit) begin
      tx_byte = 8'h00;
    end else if (st.bsel) begin
      tx_byte = sel_val[7:0];
    end else begin
      tx_byte = {4'h0, sel_val[`VAL_MSB:8]};
    end
  end

  assign rise = scl_f & ~st.scl_q;
  assign fall = ~scl_f & st.scl_q;
  assign start = scl_f & st.scl_q & st.sda_q & ~sda_f;
  assign stop = scl_f & st.scl_q & ~st.sda_q & sda_f;
  assign wr_val = {st.wr_msb[3:0], st.sh};

  // ----------------------------------------
  // monitor and serial slave
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.scl_q = scl_f;
    next_st.sda_q = sda_f;
    next_st.tgl_q = tgl_s;
    set = 8'h00;
    clr = 1'b0;
    tx_load = 1'b0;
    wr_en = 1'b0;

    // window compare with release margin
    if (cv_evt) begin
      if (cv_val > c_up) begin
        set[{cv_ch, `FLAG_ABOVE}] = 1'b1;
        next_st.above[cv_ch] = 1'b1;
      end else if ({1'b0, cv_val} + {1'b0, c_m} < {1'b0, c_up}) begin
        next_st.above[cv_ch] = 1'b0;
      end
      if (cv_val < c_lo) begin
        set[{cv_ch, `FLAG_BELOW}] = 1'b1;
        next_st.below[cv_ch] = 1'b1;
      end else if ({1'b0, cv_val} > {1'b0, c_lo} + {1'b0, c_m}) begin
        next_st.below[cv_ch] = 1'b0;
      end
    end

    // no stretching: scl is never driven; only the own address acks
    if (start) begin
      next_st.state = ST_ADDR;
      next_st.cnt = 4'h0;
      next_st.oe = 1'b0;
    end else if (stop) begin
      next_st.state = ST_IDLE;
      next_st.oe = 1'b0;
    end else begin
      unique case (st.state)
        ST_IDLE: begin
          next_st.oe = 1'b0;
        end
        ST_ADDR: begin
          if (rise) begin
            next_st.sh = {st.sh[6:0], sda_f};
            next_st.cnt = st.cnt + 4'h1;
          end else if (fall && st.cnt == 4'h8) begin
            if (st.sh[7:1] == {`ADDR_PREFIX, strap_s}) begin
              next_st.state = ST_ADDR_ACK;
              next_st.oe = 1'b1;
              next_st.rw = st.sh[0];
              next_st.bsel = 1'b0;
              next_st.phase = 2'h0;
            end else begin
              next_st.state = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (fall) begin
            next_st.cnt = 4'h0;
            if (st.rw) begin
              tx_load = 1'b1;
              next_st.state = ST_TX;
              next_st.sh = tx_byte;
              next_st.oe = ~tx_byte[7];
            end else begin
              next_st.state = ST_RX;
              next_st.oe = 1'b0;
            end
          end
        end
        ST_RX: begin
          if (rise) begin
            next_st.sh = {st.sh[6:0], sda_f};
            next_st.cnt = st.cnt + 4'h1;
          end else if (fall && st.cnt == 4'h8) begin
            next_st.state = ST_RX_ACK;
            next_st.oe = 1'b1;
            // pointer, then msb, then lsb; the next byte is a pointer
            unique case (st.phase)
              2'h0: begin
                next_st.ptr = st.sh;
                next_st.phase = 2'h1;
              end
              2'h1: begin
                next_st.wr_msb = st.sh;
                next_st.phase = 2'h2;
              end
              default: begin
                wr_en = 1'b1;
                next_st.phase = 2'h0;
              end
            endcase
          end
        end
        ST_RX_ACK: begin
          if (fall) begin
            next_st.oe = 1'b0;
            next_st.cnt = 4'h0;
            next_st.state = ST_RX;
          end
        end
        ST_TX: begin
          if (rise) begin
            next_st.cnt = st.cnt + 4'h1;
            if (st.cnt == 4'h3 && st.ptr == `OFF_ALERT) begin
              clr = 1'b1;
            end
          end else if (fall) begin
            if (st.cnt == 4'h8) begin
              next_st.state = ST_TX_ACK;
              next_st.oe = 1'b0;
              next_st.bsel = ~st.bsel;
            end else begin
              next_st.sh = {st.sh[6:0], 1'b0};
              next_st.oe = ~st.sh[6];
            end
          end
        end
        ST_TX_ACK: begin
          if (rise) begin
            next_st.nack = sda_f;
          end else if (fall) begin
            next_st.cnt = 4'h0;
            if (st.nack) begin
              next_st.state = ST_IDLE;
            end else begin
              tx_load = 1'b1;
              next_st.state = ST_TX;
              next_st.sh = tx_byte;
              next_st.oe = ~tx_byte[7];
            end
          end
        end
        default: begin
          next_st.state = ST_IDLE;
          next_st.oe = 1'b0;
        end
      endcase
    end

    // writes to the flag pointer fall through: it holds no write path
    if (wr_en && hit) begin
      unique case (skind)
        2'h0: next_st.lower[sch] = wr_val;
        2'h1: next_st.upper[sch] = wr_val;
        default: next_st.margin[sch] = wr_val;
      endcase
    end

    // a violation in the clearing cycle survives the clear
    next_st.flags = (clr ? 8'h00 : st.flags) | set;
    next_st.pin = |{next_st.above, next_st.below};
  end

  always_ff @(posedge clk or negedge rst_q) begin
    if (!rst_q) begin
      st <= MON_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = st.oe;
  assign shared_flag_output_pin = st.pin;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_flags_ro;
    @(posedge clk) disable iff (!rst_q)
      !cv_evt |=> (st.flags & ~$past(st.flags)) == 8'h00;
  endproperty
  a_flags_ro: assert property (p_flags_ro)
    else $error("flag set without a conversion");

  property p_pin;
    @(posedge clk) disable iff (!rst_q)
      cv_evt && (cv_val > c_up || cv_val < c_lo) |=> shared_flag_output_pin;
  endproperty
  a_pin: assert property (p_pin)
    else $error("alert output not raised on violation");

  property p_above;
    @(posedge clk) disable iff (!rst_q)
      cv_evt && cv_val > c_up |=> st.flags[{$past(cv_ch), 1'b0}];
  endproperty
  a_above: assert property (p_above)
    else $error("above flag missing");

  property p_below;
    @(posedge clk) disable iff (!rst_q)
      cv_evt && cv_val < c_lo |=> st.flags[{$past(cv_ch), 1'b1}];
  endproperty
  a_below: assert property (p_below)
    else $error("below flag missing");

  property p_accumulate;
    @(posedge clk) disable iff (!rst_q)
      !clr |=> (st.flags & $past(st.flags)) == $past(st.flags);
  endproperty
  a_accumulate: assert property (p_accumulate)
    else $error("flag lost without a read");

  property p_clear;
    @(posedge clk) disable iff (!rst_q)
      st.state == ST_TX && rise && st.cnt == 4'h3 && st.ptr == `OFF_ALERT
      && !cv_evt |=> st.flags == 8'h00;
  endproperty
  a_clear: assert property (p_clear)
    else $error("flags not cleared at fourth clock");

  property p_msb_reserved;
    @(posedge clk) disable iff (!rst_q)
      tx_load && st.ptr != `OFF_ALERT && !st.bsel |=> st.sh[7:4] == 4'h0;
  endproperty
  a_msb_reserved: assert property (p_msb_reserved)
    else $error("reserved bits read nonzero");

  property p_write;
    @(posedge clk) disable iff (!rst_q)
      wr_en && hit && skind == 2'h1 |=> st.upper[$past(sch)] == $past(wr_val);
  endproperty
  a_write: assert property (p_write)
    else $error("upper bound write lost");

  property p_release;
    @(posedge clk) disable iff (!rst_q)
      (~st.above & $past(st.above)) != 4'h0 |-> $past(cv_evt);
  endproperty
  a_release: assert property (p_release)
    else $error("alert released without a conversion");

  property p_drive_low_scl;
    @(posedge clk) disable iff (!rst_q)
      $rose(sda_oe) |-> !scl_f;
  endproperty
  a_drive_low_scl: assert property (p_drive_low_scl)
    else $error("sda driven while scl high");
endmodule

// [alert_mon_cfg.svh]
`ifndef ALERT_MON_CFG_SVH
`define ALERT_MON_CFG_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 4
`define SPIKE_NS 50
`define SPIKE_CYC ((`SPIKE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------
// serial address and register pointers
// ----------------------------------------
`define ADDR_PREFIX 3'h2
`define OFF_ALERT 8'h01
`define OFF_LOWER0 8'h04
`define OFF_STRIDE 8'h03

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define FLAG_ABOVE 1'b0
`define FLAG_BELOW 1'b1
`define VAL_MSB 11
`define RST_FLAGS 8'h00
`define RST_LOWER 12'h000
`define RST_UPPER 12'hfff
`define RST_MARGIN 12'hfff

`endif

// [limits_pkg.sv]
package limits_pkg;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_ADDR_ACK = 7'h04,
    ST_RX = 7'h08,
    ST_RX_ACK = 7'h10,
    ST_TX = 7'h20,
    ST_TX_ACK = 7'h40
  } bus_state_t;

  typedef struct packed {
    logic q;
    logic [7:0] cnt;
  } filt_state_t;

  typedef struct packed {
    logic tgl;
    logic [1:0] ch;
    logic [11:0] val;
  } conv_state_t;

  typedef struct packed {
    bus_state_t state;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic nack;
    logic bsel;
    logic [1:0] phase;
    logic [7:0] ptr;
    logic [7:0] wr_msb;
    logic scl_q;
    logic sda_q;
    logic tgl_q;
    logic [7:0] flags;
    logic [3:0][11:0] lower;
    logic [3:0][11:0] upper;
    logic [3:0][11:0] margin;
    logic [3:0] above;
    logic [3:0] below;
    logic pin;
    logic oe;
  } mon_state_t;

endpackage

// [sync2.sv]
`timescale 1ns/100ps
module sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  // first stage feeds only the second
  always_comb begin
    next_st = st;
    next_st.s1 = d;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{s1: INIT, s2: INIT};
    end else begin
      st <= next_st;
    end
  end

  assign q = st.s2;
endmodule

// [spike_filter.sv]
`timescale 1ns/100ps
module spike_filter
  import limits_pkg::*;
#(
  parameter logic [7:0] CYC = 8'h0d
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);
  filt_state_t st;
  filt_state_t next_st;

  // ----------------------------------------
  // spike suppression
  // ----------------------------------------
  // a level must hold CYC cycles before it is passed on
  always_comb begin
    next_st = st;
    if (d == st.q) begin
      next_st.cnt = 8'h00;
    end else if (st.cnt == CYC - 8'h01) begin
      next_st.q = d;
      next_st.cnt = 8'h00;
    end else begin
      next_st.cnt = st.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{q: 1'b1, cnt: 8'h00};
    end else begin
      st <= next_st;
    end
  end

  assign q = st.q;

  property p_spike_hold;
    @(posedge clk) disable iff (!rst_n)
      $changed(st.q) |-> $past(st.cnt) == CYC - 8'h01;
  endproperty
  a_spike_hold: assert property (p_spike_hold)
    else $error("filter output moved before hold time");
endmodule

// [i2c_master_model.sv]
`timescale 1ns/100ps
// ----------------------------------------
// bus master: open drain, 1 means released
// ----------------------------------------
module i2c_master_model (
  input wire logic clk,
  input wire logic sda_bus,
  output logic scl,
  output logic sda_m
);
  // quarter bit of 100 ns keeps data changes clear of the filtered scl edges
  localparam int Q = 25;
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic start_c();
    tick(Q);
    sda_m = 1'b0;
    tick(Q);
    scl = 1'b0;
  endtask
  task automatic stop_c();
    tick(Q);
    sda_m = 1'b0;
    tick(Q);
    scl = 1'b1;
    tick(Q);
    sda_m = 1'b1;
    tick(Q);
  endtask
  task automatic xbit(input logic b, output logic r);
    tick(Q);
    sda_m = b;
    tick(Q);
    scl = 1'b1;
    tick(Q);
    r = sda_bus;
    tick(Q);
    scl = 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) xbit(d[i], r);
    xbit(1'b1, ack);
  endtask
  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) xbit(1'b1, d[i]);
    xbit(nack, r);
  endtask
  // a read cannot carry the pointer, so it goes in a write of its own
  task automatic set_ptr(input logic [6:0] a, input logic [7:0] p, output logic [1:0] k);
    start_c();
    wbyte({a, 1'b0}, k[1]);
    wbyte(p, k[0]);
    stop_c();
  endtask
endmodule

// [adc_limit_alert_monitor_tb.sv]
`timescale 1ns/100ps
`include "alert_mon_cfg.svh"
module adc_limit_alert_monitor_tb;
  logic clk = 1'b0;
  logic conv_clk = 1'b0;
  logic rst_n = 1'b0;
  logic conv_done = 1'b0;
  logic [1:0] conv_channel = 2'h0;
  logic [11:0] conv_result = 12'h000;
  logic sda_out, sda_oe, pin, scl, sda_m, sda_bus;
  int bad_count = 0;
  int cmp_count = 0;
  localparam logic [6:0] ADR = {`ADDR_PREFIX, 4'h5};
  always #2 clk = ~clk;
  always #3 conv_clk = ~conv_clk;
  // pull-up on the data wire
  assign sda_bus = sda_m & ~(sda_oe & ~sda_out);
  adc_limit_alert_monitor adc_limit_alert_monitor_i (.clk(clk), .rst_n(rst_n),
    .conv_clk(conv_clk), .conv_done(conv_done), .conv_channel(conv_channel),
    .conv_result(conv_result), .addr_strap(4'h5), .scl_in(scl), .sda_in(sda_bus),
    .sda_out(sda_out), .sda_oe(sda_oe), .shared_flag_output_pin(pin));
  i2c_master_model i2c_master_model_i (.clk(clk), .sda_bus(sda_bus), .scl(scl),
    .sda_m(sda_m));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  function automatic logic [7:0] ptr(input int ch, input int k);
    return 8'(`OFF_LOWER0 + `OFF_STRIDE * ch + k);
  endfunction
  task automatic rd(input logic [7:0] p, input int n, output logic [15:0] v);
    logic [1:0] a;
    logic [7:0] b;
    v = 16'h0000;
    i2c_master_model_i.set_ptr(ADR, p, a);
    chk(16'(a), 16'h0000, "ptr ack");
    i2c_master_model_i.start_c();
    i2c_master_model_i.wbyte({ADR, 1'b1}, a[0]);
    chk(16'(a[0]), 16'h0000, "rd ack");
    for (int i = 0; i < n; i++) begin
      i2c_master_model_i.rbyte(1'(i == n - 1), b);
      v = {v[7:0], b};
    end
    i2c_master_model_i.stop_c();
  endtask
  task automatic wr(input logic [7:0] p, input logic [15:0] d);
    logic [3:0] a;
    i2c_master_model_i.start_c();
    i2c_master_model_i.wbyte({ADR, 1'b0}, a[3]);
    i2c_master_model_i.wbyte(p, a[2]);
    i2c_master_model_i.wbyte(d[15:8], a[1]);
    i2c_master_model_i.wbyte(d[7:0], a[0]);
    i2c_master_model_i.stop_c();
    chk(16'(a), 16'h0000, "wr ack");
  endtask
  // spacing of 14 conv clocks keeps events from merging across the crossing
  task automatic conv(input logic [1:0] ch, input logic [11:0] r);
    @(negedge conv_clk);
    conv_channel = ch;
    conv_result = r;
    conv_done = 1'b1;
    @(negedge conv_clk);
    conv_done = 1'b0;
    repeat (12) @(negedge conv_clk);
    repeat (8) @(negedge clk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [15:0] v;
    chk(16'(pin), 16'h0000, "pin idle");
    rd(`OFF_ALERT, 1, v);
    chk(v, 16'h0000, "flags");
    rd(ptr(3, 0), 2, v);
    chk(v, 16'h0000, "lower3");
    rd(ptr(3, 1), 2, v);
    chk(v, 16'h0fff, "upper3");
    rd(ptr(3, 2), 2, v);
    chk(v, 16'h0fff, "margin3");
    $display("test reset done");
  endtask
  task automatic t_regs();
    logic [15:0] v;
    logic a;
    wr(ptr(1, 0), 16'hf123);
    rd(ptr(1, 0), 2, v);
    chk(v, 16'h0123, "lower1");
    wr(ptr(2, 2), 16'hfabc);
    rd(ptr(2, 2), 2, v);
    chk(v, 16'h0abc, "margin2");
    wr(ptr(0, 1), 16'hf800);
    wr(ptr(2, 0), 16'h0100);
    wr(`OFF_ALERT, 16'hffff);
    rd(`OFF_ALERT, 1, v);
    chk(v, 16'h0000, "flags after write");
    // general call and a foreign address must both go unanswered
    foreach (v[i]) begin
      if (i < 2) begin
        i2c_master_model_i.start_c();
        i2c_master_model_i.wbyte(i == 0 ? 8'h00 : {3'h2, 4'ha, 1'b0}, a);
        i2c_master_model_i.stop_c();
        chk(16'(a), 16'h0001, "no ack");
      end
    end
    $display("test registers done");
  endtask
  task automatic t_alert();
    logic [15:0] v;
    conv(2'h1, 12'hfff);
    conv(2'h0, 12'h800);
    conv(2'h2, 12'h100);
    chk(16'(pin), 16'h0000, "bounds equal");
    conv(2'h0, 12'h801);
    chk(16'(pin), 16'h0001, "above");
    conv(2'h2, 12'h0ff);
    conv(2'h1, 12'h122);
    rd(`OFF_ALERT, 2, v);
    chk(16'(v[15:8]), 16'h0029, "flags");
    chk(16'(v[7:0]), 16'h0000, "cleared mid read");
    rd(`OFF_ALERT, 1, v);
    chk(v, 16'h0000, "flags after read");
    chk(16'(pin), 16'h0001, "pin held");
    $display("test alert done");
  endtask
  task automatic t_release();
    logic [15:0] v;
    logic [1:0] ch[5] = '{2'h1, 2'h0, 2'h0, 2'h2, 2'h2};
    logic [11:0] r[5] = '{12'h124, 12'h7f0, 12'h7ef, 12'h110, 12'h111};
    logic ex[5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    wr(ptr(0, 2), 16'h0010);
    wr(ptr(1, 2), 16'h0000);
    wr(ptr(2, 2), 16'h0010);
    for (int i = 0; i < 5; i++) begin
      conv(ch[i], r[i]);
      chk(16'(pin), 16'(ex[i]), "release step");
    end
    rd(`OFF_ALERT, 1, v);
    chk(v, 16'h0000, "no flags in range");
    $display("test release done");
  endtask
  task automatic close_out();
    $display("counts: %0d compares, %0d mismatches", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (30) @(negedge clk);
    t_reset();
    t_regs();
    t_alert();
    t_release();
    close_out();
  end
  initial begin
    repeat (95000) @(posedge clk);
    bad_count++;
    $display("CHECK FAILED t=%0t run timeout", $time);
    close_out();
  end
endmodule
